/* File: core/sct_bit_timer.sv */
// Bit timer: divides the transmit clock into serial bit periods.
// Assumes the rate code may change at any time; a shortened period
// simply ends at the next cycle.
`timescale 1ns/10ps
module sct_bit_timer
  import sct_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] rate,
  output logic            bit_end,
  output logic            bit_mid,
  output logic            bit_clk
);

  logic [6:0] cnt_reg;
  logic [6:0] cnt_next;
  logic [6:0] div;
  logic       clk_reg;
  logic       clk_next;

  function automatic logic [6:0] div_of(input logic [1:0] r);
    if (r == RATE_X16) begin
      div_of = DIV_X16;
    end else if (r == RATE_X32) begin
      div_of = DIV_X32;
    end else if (r == RATE_X64) begin
      div_of = DIV_X64;
    end else begin
      div_of = DIV_X1;
    end
  endfunction : div_of

  always_comb begin
    div      = div_of(rate);
    bit_end  = (cnt_reg >= div - 7'h01);
    bit_mid  = (cnt_reg == (div >> 1) - {6'h00, div != DIV_X1});
    cnt_next = bit_end ? 7'h00 : cnt_reg + 7'h01;
    // High in the first half of each bit; at one clock per bit it
    // cannot toggle, so it stays high
    clk_next = (div == DIV_X1) ? 1'b1 : (cnt_next < (div >> 1));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 7'h00;
      clk_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_next;
      clk_reg <= clk_next;
    end
  end

  assign bit_clk = clk_reg;

endmodule : sct_bit_timer

/* File: core/sct_pkg.sv */
// Shared constants and types of the synchronous character transmitter.
// Assumes a single clock domain; no surrounding package is needed.
package sct_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register map of the plain register port
  localparam logic [7:0] OFS_STATUS  = 8'h00;
  localparam logic [7:0] OFS_MASK    = 8'h04;
  localparam logic [7:0] OFS_FLAGS   = 8'h08;
  localparam logic [7:0] OFS_CONTROL = 8'h0c;

  // Event bits of the status and mask registers
  localparam int EV_HOLD_EMPTY = 0;
  localparam int EV_FILL_SENT  = 1;
  localparam int NUM_EVENTS    = 2;

  // Reset values
  localparam logic [7:0] FILL_RESET = 8'hff;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [NUM_EVENTS-1:0] EV_RESET = 2'h0;

  // Mode and rate encodings
  localparam logic [1:0] MODE_SYNC = 2'h1;
  localparam logic [1:0] RATE_X1   = 2'h0;
  localparam logic [1:0] RATE_X16  = 2'h1;
  localparam logic [1:0] RATE_X32  = 2'h2;
  localparam logic [1:0] RATE_X64  = 2'h3;

  // Clock cycles per serial bit for each rate
  localparam logic [6:0] DIV_X1  = 7'h01;
  localparam logic [6:0] DIV_X16 = 7'h10;
  localparam logic [6:0] DIV_X32 = 7'h20;
  localparam logic [6:0] DIV_X64 = 7'h40;

  // Shortest word length; code 0 selects it
  localparam logic [3:0] WL_BASE = 4'h5;

  typedef struct packed {
    logic       even_parity_select;
    logic       parity_inhibit;
    logic [1:0] clock_rate_select;
    logic [1:0] mode_select_pair;
    logic [1:0] word_length_select;
  } sct_ctrl_t;

  typedef struct packed {
    logic mode_ok;
    logic busy;
    logic fill_sent;
    logic hold_empty;
  } sct_flags_t;

  typedef enum logic {TX_IDLE, TX_SEND} sct_tx_state_t;

endpackage : sct_pkg

/* File: core/sct_regs.sv */
// Register port of the transmitter: sticky event status, mask,
// flag and control readback, one interrupt line.
// Assumes one-cycle strobes, never both at once.
`timescale 1ns/10ps
module sct_regs
  import sct_pkg::*;
(
  input  wire logic [ADDR_W-1:0]     addr,
  input  wire logic [DATA_W-1:0]     wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic [NUM_EVENTS-1:0] events,
  input  sct_pkg::sct_flags_t        flags,
  input  sct_pkg::sct_ctrl_t         ctrl,
  output logic [DATA_W-1:0]          rdata,
  output logic                       irq
);

  logic [NUM_EVENTS-1:0] status_reg;
  logic [NUM_EVENTS-1:0] status_next;
  logic [NUM_EVENTS-1:0] mask_reg;
  logic [NUM_EVENTS-1:0] mask_next;
  logic [DATA_W-1:0]     rdata_reg;
  logic [DATA_W-1:0]     rdata_next;

  always_comb begin
    status_next = status_reg;
    mask_next   = mask_reg;
    rdata_next  = '0;
    if (wr && addr == OFS_STATUS) begin
      status_next = status_reg & ~wdata[NUM_EVENTS-1:0];
    end else if (wr && addr == OFS_MASK) begin
      mask_next = wdata[NUM_EVENTS-1:0];
    end
    // A new event outweighs a clear in the same cycle
    status_next = status_next | events;
    if (rd) begin
      if (addr == OFS_STATUS) begin
        rdata_next = {{(DATA_W-NUM_EVENTS){1'b0}}, status_reg};
      end else if (addr == OFS_MASK) begin
        rdata_next = {{(DATA_W-NUM_EVENTS){1'b0}}, mask_reg};
      end else if (addr == OFS_FLAGS) begin
        rdata_next = {{(DATA_W-4){1'b0}}, flags};
      end else if (addr == OFS_CONTROL) begin
        rdata_next = {{(DATA_W-8){1'b0}}, ctrl};
      end else begin
        rdata_next = '0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_reg <= EV_RESET;
      mask_reg   <= EV_RESET;
      rdata_reg  <= '0;
    end else begin
      status_reg <= status_next;
      mask_reg   <= mask_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign rdata = rdata_reg;
  assign irq   = |(status_reg & mask_reg);

endmodule : sct_regs

/* File: core/sct_transmitter.sv */
// Synchronous character transmitter: holding register, fill
// character, parity and serial shifter with contiguous characters.
// Assumes all strobes and data inputs are synchronous to CLK, which
// is the transmit register clock; RESET is the master reset.
`timescale 1ns/10ps
module sct_transmitter
  import sct_pkg::*;
(
  input  wire logic                      CLK,
  input  wire logic                      RESET,
  input  wire logic                      EVEN_PARITY_SELECT,
  input  wire logic                      PARITY_INHIBIT,
  input  wire logic                      CONTROL_LOAD_STROBE_N,
  input  wire logic [1:0]                CLOCK_RATE_SELECT,
  input  wire logic [1:0]                MODE_SELECT_PAIR,
  input  wire logic [1:0]                WORD_LENGTH_SELECT,
  input  wire logic                      FILL_REGISTER_LOAD_STROBE_N,
  input  wire logic [7:0]                FILL_CHAR_INPUTS,
  input  wire logic                      HOLDING_REGISTER_LOAD_STROBE_N,
  input  wire logic [7:0]                TX_CHAR_INPUTS,
  input  wire logic                      FILL_SENT_FLAG_RESET_N,
  input  wire logic                      CHIP_DISABLE_INPUT,
  input  wire logic                      CLEAR_TO_SEND,
  input  wire logic [sct_pkg::ADDR_W-1:0] REG_ADDR,
  input  wire logic [sct_pkg::DATA_W-1:0] REG_WDATA,
  input  wire logic                      REG_WR,
  input  wire logic                      REG_RD,
  output logic [sct_pkg::DATA_W-1:0]     REG_RDATA,
  output logic                           IRQ,
  output logic                           HOLDING_EMPTY_FLAG,
  output logic                           FILL_SENT_FLAG,
  output logic                           SERIAL_TX_OUTPUT,
  output logic                           BIT_CLOCK_OUTPUT,
  output logic                           LAST_BIT_INDICATOR_N
);

  sct_ctrl_t       ctrl_reg;
  sct_ctrl_t       ctrl_next;
  sct_ctrl_t       ctrl_in;
  logic [7:0]      fill_reg;
  logic [7:0]      fill_next;
  logic [7:0]      hold_reg;
  logic [7:0]      hold_next;
  logic            hold_empty_reg;
  logic            hold_empty_next;
  logic            fill_flag_reg;
  logic            fill_flag_next;
  sct_tx_state_t   state_reg;
  sct_tx_state_t   state_next;
  logic [7:0]      sh_reg;
  logic [7:0]      sh_next;
  logic [3:0]      bits_reg;
  logic [3:0]      bits_next;
  logic            tx_reg;
  logic            tx_next;
  logic            last_n_reg;
  logic            last_n_next;
  logic            use_fill_reg;
  logic            use_fill_next;

  logic            enable;
  logic            hold_load;
  logic            sync_mode;
  logic            bit_end;
  logic            bit_mid;
  logic            start;
  logic            pick_fill;
  logic            transfer;
  logic            fill_evt;
  logic [8:0]      frame;
  sct_flags_t      flags;

  // Builds data bits, LSB first, masked to the word length, with
  // the parity bit placed right after the last data bit.
  function automatic logic [8:0] build_frame(input logic [7:0] d,
                                             input sct_ctrl_t c);
    logic [7:0] m;
    logic       p;
    logic [3:0] pos;
    m   = d & (8'hff >> (2'h3 - c.word_length_select));
    p   = c.even_parity_select ? ^m : ~^m;
    pos = WL_BASE + {2'h0, c.word_length_select};
    build_frame = {1'b0, m};
    if (!c.parity_inhibit) begin
      build_frame[pos] = p;
    end
  endfunction : build_frame

  function automatic logic [3:0] frame_len(input sct_ctrl_t c);
    frame_len = WL_BASE + {2'h0, c.word_length_select}
              + {3'h0, ~c.parity_inhibit};
  endfunction : frame_len

  // Chip disable only blocks the load and fill-flag reset strobes; the serial side keeps running; the system ties it low
  assign enable    = ~CHIP_DISABLE_INPUT;
  assign hold_load = enable & ~HOLDING_REGISTER_LOAD_STROBE_N;
  // Only the synchronous mode is built; any other mode code parks the
  // line at mark, so a wrong control word shows as a silent line
  assign sync_mode = (ctrl_reg.mode_select_pair == MODE_SYNC);

  always_comb begin
    ctrl_in.even_parity_select = EVEN_PARITY_SELECT;
    ctrl_in.parity_inhibit     = PARITY_INHIBIT;
    ctrl_in.clock_rate_select  = CLOCK_RATE_SELECT;
    ctrl_in.mode_select_pair   = MODE_SELECT_PAIR;
    ctrl_in.word_length_select = WORD_LENGTH_SELECT;
  end

  // The timer runs free even while idle, so a start waits for the next
  // bit boundary and the first bit is always full length
  sct_bit_timer u_timer (
    .clk     (CLK),
    .rst     (RESET),
    .rate    (ctrl_reg.clock_rate_select),
    .bit_end (bit_end),
    .bit_mid (bit_mid),
    .bit_clk (BIT_CLOCK_OUTPUT)
  );

  // Control and fill character storage
  // Strobes are sampled on the clock rather than used as latches, so
  // a strobe held low acts like a transparent latch one edge late
  always_comb begin
    ctrl_next = ctrl_reg;
    fill_next = fill_reg;
    if (enable && !CONTROL_LOAD_STROBE_N) begin
      ctrl_next = ctrl_in;
    end
    if (enable && !FILL_REGISTER_LOAD_STROBE_N) begin
      fill_next = FILL_CHAR_INPUTS;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ctrl_reg <= CTRL_RESET;
      fill_reg <= FILL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
      fill_reg <= fill_next;
    end
  end

  // Serial sequencer
  // bits_reg counts the bits still to show, including the one on the
  // output; a count of one means the last bit is on the line
  always_comb begin
    state_next    = state_reg;
    sh_next       = sh_reg;
    bits_next     = bits_reg;
    tx_next       = tx_reg;
    use_fill_next = use_fill_reg;
    start         = 1'b0;
    pick_fill     = 1'b0;
    frame         = 9'h000;
    // Decide fill against the holding register at mid last bit
    if (state_reg == TX_SEND && bits_reg == 4'h1 && bit_mid) begin
      use_fill_next = hold_empty_reg;
    end
    case (state_reg)
      TX_IDLE: begin
        if (bit_end && sync_mode && CLEAR_TO_SEND &&
            !hold_empty_reg) begin
          start = 1'b1;
        end
      end
      TX_SEND: begin
        if (bit_end) begin
          if (bits_reg > 4'h1) begin
            tx_next   = sh_reg[0];
            sh_next   = {1'b0, sh_reg[7:1]};
            bits_next = bits_reg - 4'h1;
          end else if (CLEAR_TO_SEND && sync_mode) begin
            start = 1'b1;
            // At one clock per bit the middle and end coincide
            pick_fill = bit_mid ? hold_empty_reg : use_fill_reg;
          end else begin
            state_next = TX_IDLE;
            tx_next    = 1'b1;
            bits_next  = 4'h0;
          end
        end
      end
      default: begin
        state_next = TX_IDLE;
      end
    endcase
    if (start) begin
      frame      = build_frame(pick_fill ? fill_reg : hold_reg,
                               ctrl_reg);
      tx_next    = frame[0];
      sh_next    = frame[8:1];
      bits_next  = frame_len(ctrl_reg);
      state_next = TX_SEND;
    end
    last_n_next = !(state_next == TX_SEND && bits_next == 4'h1);
  end

  // Exactly one of these pulses per character start; the register
  // port turns them into sticky status bits
  assign transfer = start & ~pick_fill;
  assign fill_evt = start & pick_fill;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_reg    <= TX_IDLE;
      sh_reg       <= 8'h00;
      bits_reg     <= 4'h0;
      tx_reg       <= 1'b1;
      last_n_reg   <= 1'b1;
      use_fill_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      sh_reg       <= sh_next;
      bits_reg     <= bits_next;
      tx_reg       <= tx_next;
      last_n_reg   <= last_n_next;
      use_fill_reg <= use_fill_next;
    end
  end

  // Holding register and flags
  // A load while full overwrites the held character; the loading
  // party is expected to watch the empty flag first
  always_comb begin
    hold_next       = hold_reg;
    hold_empty_next = hold_empty_reg;
    fill_flag_next  = fill_flag_reg;
    if (transfer) begin
      hold_empty_next = 1'b1;
    end
    // A load in the transfer cycle keeps the new character
    if (hold_load) begin
      hold_next       = TX_CHAR_INPUTS;
      hold_empty_next = 1'b0;
    end
    if (enable && !FILL_SENT_FLAG_RESET_N) begin
      fill_flag_next = 1'b0;
    end
    if (fill_evt) begin
      fill_flag_next = 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      hold_reg       <= 8'h00;
      hold_empty_reg <= 1'b1;
      fill_flag_reg  <= 1'b0;
    end else begin
      hold_reg       <= hold_next;
      hold_empty_reg <= hold_empty_next;
      fill_flag_reg  <= fill_flag_next;
    end
  end

  // Flag word for the register port readback
  always_comb begin
    flags.mode_ok    = sync_mode;
    flags.busy       = (state_reg == TX_SEND);
    flags.fill_sent  = fill_flag_reg;
    flags.hold_empty = hold_empty_reg;
  end

  sct_regs u_regs (
    .addr   (REG_ADDR),
    .wdata  (REG_WDATA),
    .wr     (REG_WR),
    .rd     (REG_RD),
    .clk    (CLK),
    .rst    (RESET),
    .events ({fill_evt, transfer}),
    .flags  (flags),
    .ctrl   (ctrl_reg),
    .rdata  (REG_RDATA),
    .irq    (IRQ)
  );

  assign HOLDING_EMPTY_FLAG   = hold_empty_reg;
  assign FILL_SENT_FLAG       = fill_flag_reg;
  assign SERIAL_TX_OUTPUT     = tx_reg;
  assign LAST_BIT_INDICATOR_N = last_n_reg;

endmodule : sct_transmitter

/* File: verification/sct_host_model.sv */
// Host model: loads queued characters into the holding register.
// Assumes the holding-empty flag is high while a load is welcome.
`timescale 1ns/10ps
module sct_host_model (
  input  wire logic       clk,
  input  wire logic       empty,
  input  wire logic [7:0] delay,
  output logic            load_n,
  output logic [7:0]      data
);
  logic [7:0] q[$];
  int         waited = 0;

  task automatic push(input logic [7:0] c);
    q.push_back(c);
  endtask : push

  initial begin
    load_n = 1'b1;
    data = 8'h00;
  end

  // A slow host waits; it never overwrites a full holding register
  always @(posedge clk) begin
    if (!load_n) begin
      load_n <= 1'b1;
      data <= ~data;  // Released lines must not look like a character
      waited <= 0;
    end else if (empty && q.size() > 0) begin
      if (waited >= delay) begin
        load_n <= 1'b0;
        data <= q.pop_front();
      end else
        waited <= waited + 1;
    end
  end
endmodule : sct_host_model

/* File: verification/sct_transmitter_properties.sv */
// Port checker of the transmitter.
// Assumes one clock, CLK, and asynchronous master RESET.
`timescale 1ns/10ps
module sct_transmitter_checker (
  input wire logic        CLK,
  input wire logic        RESET,
  input wire logic        CHIP_DISABLE_INPUT,
  input wire logic        HOLDING_REGISTER_LOAD_STROBE_N,
  input wire logic        FILL_SENT_FLAG_RESET_N,
  input wire logic        CLEAR_TO_SEND,
  input wire logic        REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic        HOLDING_EMPTY_FLAG,
  input wire logic        FILL_SENT_FLAG,
  input wire logic        SERIAL_TX_OUTPUT,
  input wire logic        BIT_CLOCK_OUTPUT,
  input wire logic        LAST_BIT_INDICATOR_N
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  a_reset_state:
    assert property (disable iff (1'b0) RESET |-> SERIAL_TX_OUTPUT &&
      HOLDING_EMPTY_FLAG && !FILL_SENT_FLAG && LAST_BIT_INDICATOR_N)
    else $error("reset state wrong");
  a_load_clears:
    assert property (!HOLDING_REGISTER_LOAD_STROBE_N && !CHIP_DISABLE_INPUT
      |=> !HOLDING_EMPTY_FLAG) else $error("load kept empty flag");
  a_start_cts:
    assert property ($rose(HOLDING_EMPTY_FLAG) |-> $past(CLEAR_TO_SEND))
    else $error("start without clear to send");
  a_fill_empty:
    assert property ($rose(FILL_SENT_FLAG) |-> $past(HOLDING_EMPTY_FLAG))
    else $error("fill sent while loaded");
  a_fill_sticky:
    assert property (FILL_SENT_FLAG && (FILL_SENT_FLAG_RESET_N ||
      CHIP_DISABLE_INPUT) |=> FILL_SENT_FLAG) else $error("fill flag lost");
  a_last_steady:
    assert property (!LAST_BIT_INDICATOR_N && !$fell(LAST_BIT_INDICATOR_N)
      |-> $stable(SERIAL_TX_OUTPUT)) else $error("last bit changed");
  a_bitclk_half:
    assert property ($rose(BIT_CLOCK_OUTPUT) |-> BIT_CLOCK_OUTPUT[*8])
    else $error("bit clock half too short");
  a_shift_edge:
    assert property ($changed(SERIAL_TX_OUTPUT) |-> BIT_CLOCK_OUTPUT)
    else $error("shift off bit start");
  a_rdata_quiet:
    assert property (!REG_RD |=> REG_RDATA == 32'h0)
    else $error("read data outside read slot");
endmodule : sct_transmitter_checker

bind sct_transmitter sct_transmitter_checker i_sct_transmitter_checker (
  .CLK(CLK), .RESET(RESET), .CHIP_DISABLE_INPUT(CHIP_DISABLE_INPUT),
  .HOLDING_REGISTER_LOAD_STROBE_N(HOLDING_REGISTER_LOAD_STROBE_N),
  .FILL_SENT_FLAG_RESET_N(FILL_SENT_FLAG_RESET_N),
  .CLEAR_TO_SEND(CLEAR_TO_SEND), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .HOLDING_EMPTY_FLAG(HOLDING_EMPTY_FLAG), .FILL_SENT_FLAG(FILL_SENT_FLAG),
  .SERIAL_TX_OUTPUT(SERIAL_TX_OUTPUT), .BIT_CLOCK_OUTPUT(BIT_CLOCK_OUTPUT),
  .LAST_BIT_INDICATOR_N(LAST_BIT_INDICATOR_N));

/* File: verification/sct_transmitter_tb.sv */
// Bench of the synchronous character transmitter.
// Assumes the bound checker and the host model on the load side.
`timescale 1ns/10ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module sct_transmitter_tb;
  import sct_pkg::*;
  logic clk = 1'b0, rst = 1'b0, ctrl_n = 1'b1, fill_n = 1'b1, fsr_n = 1'b1;
  logic cd = 1'b0, cts = 1'b0, rd = 1'b0, wr = 1'b0;
  logic        load_n, empty, fsent, ser, bclk, last_n, irq;
  logic [7:0]  fill_d = 8'h00, addr = 8'h00, host_delay = 8'h00, tx_d;
  logic [31:0] wdata = 32'h0, rdata;
  sct_ctrl_t   ctl_in = '0, cur = '0;
  int          n_fail = 0, n_compared = 0;
  int          divs[4] = '{1, 16, 32, 64};

  always #25 clk = ~clk;

  sct_transmitter i_sct_transmitter (.CLK(clk), .RESET(rst),
    .EVEN_PARITY_SELECT(ctl_in.even_parity_select),
    .PARITY_INHIBIT(ctl_in.parity_inhibit), .CONTROL_LOAD_STROBE_N(ctrl_n),
    .CLOCK_RATE_SELECT(ctl_in.clock_rate_select),
    .MODE_SELECT_PAIR(ctl_in.mode_select_pair),
    .WORD_LENGTH_SELECT(ctl_in.word_length_select),
    .FILL_REGISTER_LOAD_STROBE_N(fill_n), .FILL_CHAR_INPUTS(fill_d),
    .HOLDING_REGISTER_LOAD_STROBE_N(load_n), .TX_CHAR_INPUTS(tx_d),
    .FILL_SENT_FLAG_RESET_N(fsr_n), .CHIP_DISABLE_INPUT(cd),
    .CLEAR_TO_SEND(cts), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .IRQ(irq), .HOLDING_EMPTY_FLAG(empty),
    .FILL_SENT_FLAG(fsent), .SERIAL_TX_OUTPUT(ser),
    .BIT_CLOCK_OUTPUT(bclk), .LAST_BIT_INDICATOR_N(last_n));

  sct_host_model i_sct_host_model (.clk(clk), .empty(empty),
    .delay(host_delay), .load_n(load_n), .data(tx_d));

  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  function automatic int nbits();
    return 5 + int'(cur.word_length_select) + int'(!cur.parity_inhibit);
  endfunction : nbits

  function automatic logic [31:0] frame(input logic [7:0] c);
    logic [7:0] b;
    b = c & (8'hff >> (3 - cur.word_length_select));
    frame = {24'h0, b};
    if (!cur.parity_inhibit)
      frame[5 + cur.word_length_select] = cur.even_parity_select ? ^b : ~^b;
  endfunction : frame

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `CHK(rdata, e)
  endtask : reg_chk

  task automatic set_ctrl(input logic e, input logic p, input logic [1:0] r,
                          input logic [1:0] w);
    cur = '{e, p, r, MODE_SYNC, w};
    @(posedge clk);
    ctl_in <= cur;
    ctrl_n <= 1'b0;
    @(posedge clk);
    ctrl_n <= 1'b1;
  endtask : set_ctrl

  task automatic fill_load(input logic [7:0] c);
    @(posedge clk);
    fill_n <= 1'b0;
    fill_d <= c;
    @(posedge clk);
    fill_n <= 1'b1;
    fill_d <= ~c;
  endtask : fill_load

  task automatic wait_empty(input logic v);
    int k;
    for (k = 0; k < 300 && empty !== v; k++)
      @(negedge clk);
    if (k == 300) begin
      n_fail++;
      end_sim();
    end
  endtask : wait_empty

  // Samples mid-bit so a one-cycle skew of the flag cannot mislead
  task automatic capture(input logic [31:0] s, input int n);
    int d;
    d = divs[cur.clock_rate_select];
    wait_empty(1'b0);
    wait_empty(1'b1);
    repeat (d / 2) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      `CHK(ser, s[i])
      repeat (d) @(negedge clk);
    end
  endtask : capture

  task automatic stop_line;
    @(posedge clk);
    cts <= 1'b0;
    repeat (20 * divs[cur.clock_rate_select] + 4) @(negedge clk);
    for (int i = 0; i < 12; i++) begin
      `CHK(ser, 1'b1)
      @(negedge clk);
    end
  endtask : stop_line

  task automatic send_pair(input logic [7:0] c, input logic [7:0] f);
    @(posedge clk);
    cts <= 1'b1;
    i_sct_host_model.push(c);
    capture(frame(c) | frame(f) << nbits(), 2 * nbits());
    stop_line();
  endtask : send_pair

  task automatic t_reset;
    @(negedge clk);
    `CHK(ser, 1'b1)
    `CHK(empty, 1'b1)
    `CHK(last_n, 1'b1)
  endtask : t_reset

  task automatic t_stream;
    set_ctrl(1'b1, 1'b0, 2'h0, 2'h3);
    reg_chk(OFS_CONTROL, {24'h0, cur});
    @(posedge clk);
    ctl_in.even_parity_select <= 1'b0;
    reg_chk(OFS_CONTROL, {24'h0, cur});
    @(posedge clk);
    cts <= 1'b1;
    i_sct_host_model.push(8'h35);
    i_sct_host_model.push(8'hca);
    capture(frame(8'h35) | frame(8'hca) << 9 | frame(8'hff) << 18,
            27);
    `CHK(fsent, 1'b1)
    stop_line();
    @(posedge clk);
    fsr_n <= 1'b0;
    @(posedge clk);
    fsr_n <= 1'b1;
    @(negedge clk);
    `CHK(fsent, 1'b0)
  endtask : t_stream

  task automatic t_formats;
    for (int w = 0; w < 4; w++)
      for (int p = 0; p < 3; p++) begin
        host_delay <= 8'(3 * p);
        set_ctrl(p == 1, p == 2, 2'h0, 2'(w));
        fill_load(8'h5a ^ 8'(w));
        send_pair(8'hc3 + 8'(p), 8'h5a ^ 8'(w));
      end
  endtask : t_formats

  task automatic t_rates;
    for (int r = 1; r < 4; r++) begin
      set_ctrl(1'b0, 1'b1, 2'(r), 2'h0);
      fill_load(8'h0e ^ 8'(r));
      @(posedge clk);
      cd <= 1'b1;
      fill_load(8'h1f);
      @(posedge clk);
      cd <= 1'b0;
      send_pair(8'h15, 8'h0e ^ 8'(r));
    end
    set_ctrl(1'b0, 1'b0, 2'h0, 2'h3);
  endtask : t_rates

  // A mode other than synchronous must keep a loaded character back
  task automatic t_mode;
    @(posedge clk);
    ctl_in.mode_select_pair <= 2'h2;
    ctrl_n <= 1'b0;
    @(posedge clk);
    ctrl_n <= 1'b1;
    cts <= 1'b1;
    i_sct_host_model.push(8'h96);
    repeat (40) begin
      @(negedge clk);
      `CHK(ser, 1'b1)
    end
    `CHK(empty, 1'b0)
    set_ctrl(1'b0, 1'b0, 2'h0, 2'h3);
    capture(frame(8'h96) | frame(8'h0d) << 9, 18);
    stop_line();
  endtask : t_mode

  task automatic t_irq;
    reg_chk(OFS_STATUS, 32'h3);
    reg_chk(OFS_FLAGS, 32'hb);
    reg_wr(OFS_MASK, 32'h1);
    reg_chk(OFS_MASK, 32'h1);
    `CHK(irq, 1'b1)
    reg_wr(OFS_STATUS, 32'h1);
    @(negedge clk);
    `CHK(irq, 1'b0)
    reg_chk(OFS_STATUS, 32'h2);
    reg_wr(OFS_MASK, 32'h2);
    @(negedge clk);
    `CHK(irq, 1'b1)
    reg_wr(OFS_STATUS, 32'h3);
    reg_wr(8'h10, 32'hffff_ffff);
    reg_chk(8'h10, 32'h0);
    reg_chk(OFS_MASK, 32'h2);
    `CHK(irq, 1'b0)
  endtask : t_irq

  initial begin
    // Edge at time zero so outputs are known at the first clock
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_stream();
    t_formats();
    t_rates();
    t_mode();
    t_irq();
    end_sim();
  end
endmodule : sct_transmitter_tb
